// File: logic/kpk_pkg.sv
// shared constants for the keyboard port and keying control block
package kpk_pkg;
    localparam int CLK_NS = 5;
    localparam int ACK_NS = 1183;
    localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS;
    localparam int OVS = 16;
    localparam int FRAME_BITS = 10;
    localparam logic [31:0] HOLD_DEF = 32'h0bEB_C200;
    localparam int AW = 8;
    localparam logic [AW-1:0] A_KBD = 8'h00;
    localparam logic [AW-1:0] A_CTRL = 8'h04;
    localparam logic [AW-1:0] A_STAT = 8'h08;
    localparam logic [AW-1:0] A_TXD = 8'h0c;
    localparam logic [AW-1:0] A_RXD = 8'h10;
    localparam logic [AW-1:0] A_HOLD = 8'h14;
    localparam int C_KEY = 0;
    localparam int C_CWID = 1;
    localparam int C_TXREQ = 2;
    localparam int C_ROUTE = 4;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [1:0] {
        KPK_ROUTE_CMD = 2'b00,
        KPK_ROUTE_TXBUF = 2'b01,
        KPK_ROUTE_MEM = 2'b10
    } kpk_route_e;
endpackage

// File: logic/kpk_ser.sv
// byte serialiser and deserialiser at one sixteenth of their sampled clocks
`timescale 1ns/10ps
module kpk_ser
    import kpk_pkg::*;
#(
    parameter int DW = 8
)
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          tx_clk_in,
    input  wire logic          rx_clk_in,
    input  wire logic          tx_load,
    input  wire logic [DW-1:0] tx_byte,
    input  wire logic          rxd,
    input  wire logic          rx_take,
    output logic               txd,
    output logic               tx_busy,
    output logic [DW-1:0]      rx_byte,
    output logic               rx_valid
);
    logic          txc_r;
    logic          rxc_r;
    logic [DW+1:0] tx_sh_r;
    logic [3:0]    tx_left_r;
    logic [3:0]    tx_div_r;
    logic          rx_act_r;
    logic [3:0]    rx_div_r;
    logic [3:0]    rx_cnt_r;
    logic [DW-1:0] rx_sh_r;
    logic          tx_edge;
    logic          rx_edge;

    assign tx_edge = tx_clk_in & ~txc_r;
    assign rx_edge = rx_clk_in & ~rxc_r;
    assign txd = tx_sh_r[0];
    assign tx_busy = (tx_left_r != 4'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            txc_r <= 1'b0;
            rxc_r <= 1'b0;
        end
        else
        begin
            txc_r <= tx_clk_in;
            rxc_r <= rx_clk_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit: start, data lsb first, stop; each bit lasts 16 clock edges
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_sh_r <= '1;
            tx_left_r <= 4'h0;
            tx_div_r <= 4'h0;
        end
        else if (tx_load && !tx_busy)
        begin
            tx_sh_r <= {1'b1, tx_byte, 1'b0};
            tx_left_r <= 4'(FRAME_BITS);
            tx_div_r <= 4'h0;
        end
        else if (tx_edge && tx_busy)
        begin
            if (tx_div_r == 4'(OVS - 1))
            begin
                tx_div_r <= 4'h0;
                tx_sh_r <= {1'b1, tx_sh_r[DW+1:1]};
                tx_left_r <= tx_left_r - 4'h1;
            end
            else
            begin
                tx_div_r <= tx_div_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive: sample mid-bit; a high start sample or low stop drops the frame
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_act_r <= 1'b0;
            rx_div_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= '0;
            rx_byte <= '0;
            rx_valid <= 1'b0;
        end
        else
        begin
            if (rx_take)
                rx_valid <= 1'b0;
            if (rx_edge && !rx_act_r && !rxd)
            begin
                rx_act_r <= 1'b1;
                rx_div_r <= 4'h1;
                rx_cnt_r <= 4'h0;
            end
            else if (rx_edge && rx_act_r)
            begin
                rx_div_r <= rx_div_r + 4'h1;
                if (rx_div_r == 4'(OVS / 2 - 1))
                begin
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == 4'h0 && rxd)
                        rx_act_r <= 1'b0;
                    else if (rx_cnt_r == 4'(DW + 1))
                    begin
                        rx_act_r <= 1'b0;
                        if (rxd)
                        begin
                            rx_byte <= rx_sh_r;
                            rx_valid <= 1'b1;
                        end
                    end
                    else if (rx_cnt_r != 4'h0)
                        rx_sh_r <= {rxd, rx_sh_r[DW-1:1]};
                end
            end
        end
    end
endmodule

// File: logic/kpk_top.sv
// keyboard port, cw keying, rtty serial and transmit/receive control
// Behaviour
// - active-low strobe after data setup becomes one internal strobe pulse
// - strobe pulse drives the keyboard interrupt request low
// - reading the keyboard data returns the interrupt request high
// - a keyboard data read emits a 1.183 us active-low acknowledge pulse
// - a route field (command, transmit buffer or memory) is held in the control register but routes nothing
// - cw keying bit changes in step with the sampled speed clock
// - keying switches conduct while the cw keying bit is high
// - cw_identification bit follows cw keying in rtty, forcing fsk to space
// - written bytes sent serially at 1/16 of transmit clock to fsk outputs
// - fsk signal deserialised at 1/16 of receive clock into bytes
// - active hand key lights led, opens monitor gate, turns on keying
// - hand key sets transmit control and reloads the hold timer
// - hold timer expiry returns the transmitter to receive
// - rtty mode input low forces the cw decoder gate low
// - gated cw decoder is readable and drives led and tone gate
// - fsk output selects demodulated or transmit signal by board controls
// - in send the switch shorts remote line; else control switch drives it
// - send and receive switch inputs govern the transmit control switch
// - register transfers complete only on a valid qualified bus cycle
`timescale 1ns/10ps
module kpk_top
    import kpk_pkg::*;
#(
    parameter logic [31:0] HOLD_TICKS = HOLD_DEF,
    parameter int          ACK_CYCLES = ACK_CYC
)
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [7:0]    keyboard_data,
    input  wire logic          kbd_strobe_n,
    output logic               keyboard_irq_n,
    output logic               read_ack_pulse_out_n,
    input  wire logic          speed_clk_in,
    input  wire logic          hand_key,
    input  wire logic          cw_decoder_in,
    input  wire logic          mode_cw,
    input  wire logic          send_sw_n,
    input  wire logic          recv_sw_n,
    input  wire logic          send_select_ctrl,
    input  wire logic          input_source_select,
    input  wire logic          demod_in,
    input  wire logic          tx_clk_in,
    input  wire logic          rx_clk_in,
    output logic               cw_keying_line,
    output logic               keying_switch_a,
    output logic               keying_switch_b,
    output logic               cw_identification,
    output logic               fsk_keying_switch,
    output logic               fsk_ttl_out,
    output logic               cw_monitor_led,
    output logic               monitor_osc_gate,
    output logic               cw_decoder_gate,
    output logic               tx_rx_control_switch,
    output logic               tx_rx_remote_line,
    output logic               fsk_out
);
    logic              stb_q_r;
    logic              stb_pulse_r;
    logic [7:0]        kbd_data_r;
    logic              irq_r;
    logic [8:0]        ack_cnt_r;
    logic              ack_n_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0]       hold_r;
    logic [31:0]       hold_cnt_r;
    logic              spd_q_r;
    logic              cw_key_r;
    logic              key_q_r;
    logic              bvalid_r;
    logic              rvalid_r;
    logic              wr_go;
    logic              rd_go;
    logic              wr_ok;
    logic              rd_ok;
    logic              kbd_rd;
    logic              rx_rd;
    logic              tx_wr;
    logic              key_rise;
    logic              dec_g;
    logic              txd;
    logic              tx_busy;
    logic [7:0]        rx_byte;
    logic              rx_valid;
    logic              tx_on;
    logic [31:0]       rd_val;

    ////////////////////////////////////////////////////////////////////////
    // register bus slave: write address and data are taken together
    // qualified transfer
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    assign rd_go = s_axi_arvalid & ~rvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign wr_ok = (s_axi_awaddr == A_CTRL) || (s_axi_awaddr == A_TXD)
                || (s_axi_awaddr == A_HOLD);
    assign rd_ok = (s_axi_araddr <= A_HOLD) && (s_axi_araddr[1:0] == 2'h0);
    assign kbd_rd = rd_go && (s_axi_araddr == A_KBD);
    assign rx_rd = rd_go && (s_axi_araddr == A_RXD);
    assign tx_wr = wr_go && (s_axi_awaddr == A_TXD) && s_axi_wstrb[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    always_comb
    begin
        rd_val = '0;
        unique case (s_axi_araddr)
            A_KBD:  rd_val = {24'h00_0000, kbd_data_r};
            A_CTRL: rd_val = {26'h000_0000, ctrl_r};
            A_STAT: rd_val = {22'h00_0000, recv_sw_n, send_sw_n, rx_valid,
                              tx_busy, tx_on, dec_g, hand_key, mode_cw,
                              spd_q_r, irq_r};
            A_RXD:  rd_val = {24'h00_0000, rx_byte};
            A_HOLD: rd_val = hold_r;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OK;
        end
        else if (rd_go)
        begin
            rvalid_r <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= CTRL_RST;
            hold_r <= HOLD_TICKS;
        end
        else if (wr_go)
        begin
            if (s_axi_awaddr == A_CTRL && s_axi_wstrb[0])
                ctrl_r <= s_axi_wdata[CTRL_W-1:0];
            if (s_axi_awaddr == A_HOLD)
                for (int b = 0; b < 4; b++)
                    if (s_axi_wstrb[b])
                        hold_r[8*b +: 8] <= s_axi_wdata[8*b +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // keyboard port
    // strobe shaping
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stb_q_r <= 1'b1;
            stb_pulse_r <= 1'b0;
        end
        else
        begin
            stb_q_r <= kbd_strobe_n;
            stb_pulse_r <= stb_q_r & ~kbd_strobe_n;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            kbd_data_r <= 8'h00;
        else if (stb_pulse_r)
            kbd_data_r <= keyboard_data;
    end

    // request on strobe, set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_r <= 1'b0;
        else if (stb_pulse_r)
            irq_r <= 1'b1;
        else if (kbd_rd)
            irq_r <= 1'b0;
    end
    assign keyboard_irq_n = ~irq_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ack_cnt_r <= 9'h000;
            ack_n_r <= 1'b1;
        end
        else if (kbd_rd)
        begin
            ack_cnt_r <= 9'(ACK_CYCLES - 1);
            ack_n_r <= 1'b0;
        end
        else if (ack_cnt_r != 9'h000)
            ack_cnt_r <= ack_cnt_r - 9'h001;
        else
            ack_n_r <= 1'b1;
    end
    assign read_ack_pulse_out_n = ack_n_r;

    ////////////////////////////////////////////////////////////////////////
    // cw keying and monitor
    // key bit follows request on speed clock rise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            spd_q_r <= 1'b0;
            cw_key_r <= 1'b0;
        end
        else
        begin
            spd_q_r <= speed_clk_in;
            if (speed_clk_in && !spd_q_r)
                cw_key_r <= ctrl_r[C_KEY];
        end
    end

    assign dec_g = cw_decoder_in & mode_cw;
    assign cw_decoder_gate = mode_cw;
    assign keying_switch_a = cw_key_r | hand_key;
    assign keying_switch_b = cw_key_r | hand_key;
    assign cw_keying_line = cw_key_r | hand_key;
    assign cw_monitor_led = cw_key_r | hand_key | dec_g;
    assign monitor_osc_gate = cw_key_r | hand_key | dec_g;
    assign cw_identification = cw_key_r & ctrl_r[C_CWID];
    // serial output keys fsk, held at space by identification
    assign fsk_ttl_out = txd & ~cw_identification;
    assign fsk_keying_switch = txd & ~cw_identification;
    assign fsk_out = (send_select_ctrl & ~input_source_select) ? txd : demod_in;

    kpk_ser u_ser (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tx_clk_in (tx_clk_in),
        .rx_clk_in (rx_clk_in),
        .tx_load   (tx_wr),
        .tx_byte   (s_axi_wdata[7:0]),
        .rxd       (fsk_out),
        .rx_take   (rx_rd),
        .txd       (txd),
        .tx_busy   (tx_busy),
        .rx_byte   (rx_byte),
        .rx_valid  (rx_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit/receive hold timer
    assign key_rise = hand_key & ~key_q_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            key_q_r <= 1'b0;
            hold_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            key_q_r <= hand_key;
            if (key_rise || hand_key)
                hold_cnt_r <= hold_r;
            else if (hold_cnt_r != 32'h0000_0000)
                hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
        end
    end

    // receive switch forces receive, send switch forces transmit
    assign tx_on = recv_sw_n & (~send_sw_n | ctrl_r[C_TXREQ]
                 | (hold_cnt_r != 32'h0000_0000));
    assign tx_rx_control_switch = tx_on;
    // remote line left to the switch in send
    assign tx_rx_remote_line = send_sw_n & tx_on;

    ////////////////////////////////////////////////////////////////////////
    AST_ACK_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ack_cnt_r != 9'h000) |-> !ack_n_r [*8])
        else $error("ack pulse too short");
    AST_IRQ_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        stb_pulse_r |=> !keyboard_irq_n)
        else $error("strobe did not raise request");
    AST_IRQ_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
        kbd_rd && !stb_pulse_r |=> keyboard_irq_n ##0 !read_ack_pulse_out_n)
        else $error("read did not clear request");
    AST_ONE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        stb_pulse_r |=> !stb_pulse_r)
        else $error("strobe pulse too wide");
    AST_KEY_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(cw_key_r) |-> $past(speed_clk_in) && !$past(spd_q_r))
        else $error("keying moved off speed clock");
    AST_CWID: assert property (@(posedge aclk) disable iff (!aresetn)
        cw_identification |-> cw_keying_line && !fsk_ttl_out)
        else $error("identification not forcing space");
    AST_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        !mode_cw |-> !cw_decoder_gate && !dec_g)
        else $error("decoder not gated in rtty");
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        key_rise |=> hold_cnt_r == hold_r)
        else $error("hold timer not reloaded");
    AST_RECV: assert property (@(posedge aclk) disable iff (!aresetn)
        !recv_sw_n |-> !tx_rx_control_switch && !tx_rx_remote_line)
        else $error("receive switch ignored");
endmodule

// File: tb/kpk_host_model.sv
// keyboard or host model sending ascii characters over the strobed parallel port
`timescale 1ns/10ps
module kpk_host_model
(
    input  wire logic  aclk,
    input  wire logic  read_ack_pulse_out_n,
    output logic [7:0] keyboard_data,
    output logic       kbd_strobe_n
);
    initial
    begin
        keyboard_data = 8'h00;
        kbd_strobe_n  = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data, then strobe
    task automatic send(input logic [7:0] c, output bit ok);
        int i;
        @(posedge aclk);
        keyboard_data <= c;
        @(posedge aclk);
        kbd_strobe_n <= 1'b0;
        for (i = 0; i < 3000 && read_ack_pulse_out_n !== 1'b0; i++)
            @(negedge aclk);
        ok = (i < 3000);
        @(posedge aclk);
        kbd_strobe_n  <= 1'b1;
        keyboard_data <= ~c;
    endtask
endmodule

// File: tb/testbench.sv
// self-checking testbench for the keyboard port and keying control block
`timescale 1ns/10ps
module testbench
    import kpk_pkg::*;
();
    localparam logic [31:0] HT  = 32'h0000_0014;
    localparam int          LIM = 3000;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        speed_clk_in = 1'b0, hand_key = 1'b0, cw_decoder_in = 1'b0, mode_cw = 1'b1;
    logic        send_sw_n = 1'b1, recv_sw_n = 1'b1, send_select_ctrl = 1'b1;
    logic        input_source_select = 1'b0, demod_in = 1'b0, tx_clk_in = 1'b0, rx_clk_in = 1'b0;
    logic [1:0]  div = 2'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  keyboard_data;
    logic        kbd_strobe_n, keyboard_irq_n, read_ack_pulse_out_n, cw_keying_line;
    logic        keying_switch_a, keying_switch_b, cw_identification, fsk_keying_switch;
    logic        fsk_ttl_out, cw_monitor_led, monitor_osc_gate, cw_decoder_gate;
    logic        tx_rx_control_switch, tx_rx_remote_line, fsk_out;
    int          n_errors = 0, checks_done = 0, ack_cnt = 0;

    kpk_top #(.HOLD_TICKS(HT), .ACK_CYCLES(ACK_CYC)) u_kpk_top (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .keyboard_data, .kbd_strobe_n, .keyboard_irq_n,
        .read_ack_pulse_out_n, .speed_clk_in, .hand_key, .cw_decoder_in, .mode_cw,
        .send_sw_n, .recv_sw_n, .send_select_ctrl, .input_source_select, .demod_in,
        .tx_clk_in, .rx_clk_in, .cw_keying_line, .keying_switch_a, .keying_switch_b,
        .cw_identification, .fsk_keying_switch, .fsk_ttl_out, .cw_monitor_led,
        .monitor_osc_gate, .cw_decoder_gate, .tx_rx_control_switch, .tx_rx_remote_line,
        .fsk_out);
    kpk_host_model u_kpk_host_model (.aclk, .read_ack_pulse_out_n, .keyboard_data,
        .kbd_strobe_n);

    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 aclk = ~aclk;
    // serial clocks at a quarter of aclk, one bit is OVS of their rising edges
    always @(posedge aclk)
    begin
        div       <= div + 2'h1;
        tx_clk_in <= div[1];
        rx_clk_in <= div[1];
    end
    always @(negedge aclk)
        if (read_ack_pulse_out_n === 1'b0)
            ack_cnt = ack_cnt + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic lim(input int i);
        if (i >= LIM)
        begin
            n_errors++;
            $display("BAD %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge aclk);
    endtask
    // waits at settled points for one of the design's handshake levels
    task automatic wt(input int w);
        int i;
        logic [5:0] s;
        for (i = 0; i < LIM; i++)
        begin
            @(negedge aclk);
            s = {read_ack_pulse_out_n, ~keyboard_irq_n, s_axi_rvalid, s_axi_arready,
                 s_axi_bvalid, s_axi_awready};
            if (s[w] === 1'b1)
                break;
        end
        lim(i);
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        wt(0);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        wt(1);
        chk(s_axi_bresp, er, "write response");
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        wt(2);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        wt(3);
        d = s_axi_rdata;
        chk(s_axi_rresp, er, "read response");
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic spd();
        @(posedge aclk);
        speed_clk_in <= 1'b1;
        repeat (2) @(posedge aclk);
        speed_clk_in <= 1'b0;
        cyc(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(CLK_NS * 90000);
        lim(LIM);
    end
    initial
    begin
        bit ok;
        logic [31:0] d;
        int i;
        int n;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(1);
        chk({keyboard_irq_n, read_ack_pulse_out_n, fsk_ttl_out}, 32'h7, "reset idle");
        rd(A_CTRL, d, RESP_OK);
        chk(d, 32'h0000_0000, "ctrl reset");
        rd(A_HOLD, d, RESP_OK);
        chk(d, HT, "hold reset");
        rd(8'h3c, d, RESP_ERR);
        chk(d, 32'h0000_0000, "unmapped read");
        wchk(8'h3c, 32'h0000_0001, RESP_ERR);
        ack_cnt = 0;
        fork
            u_kpk_host_model.send(8'h41, ok);
            begin
                wt(4);
                rd(A_KBD, d, RESP_OK);
                chk(d, 32'h0000_0041, "keyboard data");
                cyc(1);
                chk(keyboard_irq_n, 1'b1, "irq kept after read");
            end
        join
        chk(ok, 1'b1, "no acknowledge seen");
        wt(5);
        cyc(4);
        chk(ack_cnt, ACK_CYC, "acknowledge length");
        chk(keyboard_irq_n, 1'b1, "second irq from one strobe");
        wchk(A_CTRL, 32'h0000_0010, RESP_OK);
        rd(A_CTRL, d, RESP_OK);
        chk(d, 32'h0000_0010, "route field");
        wchk(A_CTRL, 32'h0000_0003, RESP_OK);
        cyc(3);
        chk(cw_keying_line, 1'b0, "key ahead of speed clock");
        spd();
        chk({cw_keying_line, keying_switch_a, keying_switch_b}, 32'h7, "cw keying");
        chk({cw_identification, fsk_ttl_out, fsk_keying_switch}, 32'h4, "cw_identification");
        wchk(A_CTRL, 32'h0000_0000, RESP_OK);
        spd();
        chk({cw_keying_line, cw_identification}, 32'h0, "cw key off");
        @(posedge aclk);
        hand_key <= 1'b1;
        cyc(2);
        chk({cw_keying_line, cw_monitor_led, monitor_osc_gate, tx_rx_control_switch,
             tx_rx_remote_line}, 32'h1f, "hand key");
        @(posedge aclk);
        hand_key <= 1'b0;
        cyc(12);
        chk(tx_rx_control_switch, 1'b1, "hold early");
        @(posedge aclk);
        hand_key <= 1'b1;
        @(posedge aclk);
        hand_key <= 1'b0;
        cyc(15);
        chk(tx_rx_control_switch, 1'b1, "hold reload");
        cyc(10);
        chk(tx_rx_control_switch, 1'b0, "hold expiry");
        @(posedge aclk);
        hand_key  <= 1'b1;
        send_sw_n <= 1'b0;
        cyc(2);
        chk(tx_rx_remote_line, 1'b0, "send position");
        @(posedge aclk);
        send_sw_n <= 1'b1;
        recv_sw_n <= 1'b0;
        cyc(2);
        chk(tx_rx_control_switch, 1'b0, "receive position");
        @(posedge aclk);
        hand_key      <= 1'b0;
        recv_sw_n     <= 1'b1;
        cw_decoder_in <= 1'b1;
        mode_cw       <= 1'b0;
        cyc(30);
        chk({cw_decoder_gate, cw_monitor_led, monitor_osc_gate}, 32'h0, "rtty gate");
        @(posedge aclk);
        mode_cw <= 1'b1;
        cyc(2);
        chk({cw_decoder_gate, cw_monitor_led, monitor_osc_gate}, 32'h7, "decoder");
        rd(A_STAT, d, RESP_OK);
        chk(d & 32'h0000_0014, 32'h0000_0014, "decoder status");
        @(posedge aclk);
        cw_decoder_in    <= 1'b0;
        send_select_ctrl <= 1'b0;
        cyc(2);
        chk(fsk_out, 1'b0, "demodulated route");
        @(posedge aclk);
        send_select_ctrl <= 1'b1;
        cyc(2);
        chk(fsk_out, 1'b1, "transmit route");
        fork
            wchk(A_TXD, 32'h0000_00a5, RESP_OK);
            begin
                for (i = 0; i < LIM && fsk_ttl_out !== 1'b0; i++)
                    @(negedge aclk);
                lim(i);
                // start bit length depends on serial clock phase at load; time the low bit 1
                for (i = 0; i < LIM && fsk_ttl_out !== 1'b1; i++)
                    @(negedge aclk);
                lim(i);
                for (i = 0; i < LIM && fsk_ttl_out !== 1'b0; i++)
                    @(negedge aclk);
                lim(i);
                for (n = 0; n < LIM && fsk_ttl_out === 1'b0; n++)
                    @(negedge aclk);
                chk(n, OVS * 4, "data bit length");
            end
        join
        for (i = 0; i < 400; i++)
        begin
            rd(A_STAT, d, RESP_OK);
            if (d[7] === 1'b1)
                break;
        end
        lim((i < 400) ? 0 : LIM);
        rd(A_RXD, d, RESP_OK);
        chk(d & 32'h0000_00ff, 32'h0000_00a5, "received byte");
        rd(A_STAT, d, RESP_OK);
        chk(d[7], 1'b0, "rx valid cleared");
        tally_and_finish();
    end
endmodule
